// *** design/hport_defines.svh ***
/*
  Shared constants for the CPU host port pair: device address map,
  mode bits, controller register offsets and timing counts.
  Assumes a 40 MHz system clock on both ends.
*/
`ifndef HPORT_DEFINES_SVH
`define HPORT_DEFINES_SVH

// ----------------------------------------
// Device side
// ----------------------------------------
`define HP_ADDR_W 8
`define DEV_MODE_ADDR 8'h00
`define DEV_MODE_RST 8'h00
`define MODE_16X8_BIT 0
`define MODE_SPEED_BIT 1

// ----------------------------------------
// Controller registers
// ----------------------------------------
`define REG_TGT_ADDR 3'h0
`define REG_TGT_WDATA 3'h1
`define REG_CMD 3'h2
`define REG_STATUS 3'h3
`define REG_RDATA 3'h4
`define REG_CONFIG 3'h5
`define REG_SERIAL 3'h6
`define CMD_START_BIT 0
`define CMD_WRITE_BIT 1
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define CFG_SPEED_BIT 2
`define CFG_SERIAL_BIT 3

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_KHZ 40000
`define SCLK_SLOW_KHZ 4096
`define SCLK_FAST_KHZ 8192
`define SCLK_HALF_SLOW (`CLK_KHZ / (2 * `SCLK_SLOW_KHZ))
`define SCLK_HALF_FAST (`CLK_KHZ / (2 * `SCLK_FAST_KHZ))
`define ADDR_SETUP_CYC 3
`define ADDR_HOLD_CYC 4

`endif

// *** design/hport_pkg.sv ***
/*
  Types for the CPU host port pair.
  Assumes hport_defines.svh holds all numeric constants.
*/
package hport_pkg;
  typedef enum logic [1:0] {BUS_NONMUX, BUS_MUX_STROBE, BUS_MUX_RDWR} bus_style_t;
  typedef enum logic {DEV_IDLE, DEV_ACK} dev_state_t;
  typedef enum logic [2:0] {H_IDLE, H_ADDR, H_LATCH, H_STROBE, H_RELEASE} host_state_t;
endpackage

// *** design/hport_if.sv ***
/*
  Pins between the external CPU and the switch host port.
  Resolves the shared data bus and the open-drain acknowledge; undriven
  lines read as pulled high.
*/
`timescale 1ns/1ps
interface hport_if;
  import hport_pkg::*;
  logic cs_n;
  logic strobe_or_read_n;
  logic rw_or_write_n;
  logic addr_latch_strobe;
  logic [2:0] low_addr_bits;
  logic [2:0] high_addr_bits;
  bus_style_t bus_style_select;
  logic serial_clk;
  logic [7:0] host_data_out;
  logic host_data_oe;
  logic [7:0] dev_data_out;
  logic dev_data_oe;
  logic ack_oe;
  logic [7:0] host_data_bus;
  logic transfer_ack_n;

  assign host_data_bus = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : 8'hff);
  assign transfer_ack_n = ack_oe ? 1'b0 : 1'b1;

  modport device (
    input cs_n, strobe_or_read_n, rw_or_write_n, addr_latch_strobe,
    input low_addr_bits, high_addr_bits, bus_style_select, serial_clk, host_data_bus,
    output dev_data_out, dev_data_oe, ack_oe
  );
  modport host (
    output cs_n, strobe_or_read_n, rw_or_write_n, addr_latch_strobe,
    output low_addr_bits, high_addr_bits, bus_style_select, serial_clk,
    output host_data_out, host_data_oe,
    input host_data_bus, transfer_ack_n
  );
endinterface

// *** design/hport_device.sv ***
/*
  Device end of the switch CPU host port: strobe decode for the three
  bus styles, address latch, register and memory access, acknowledge,
  and reuse of the low and next address pins as extra serial inputs.
  Assumes the host keeps address and data stable through each access.
*/
// Function
// - Serial clock is 4.096 or 8.192 MHz; the host makes 5 or 10 MHz from its 40 MHz clock
// - Non-mux: low pins are address bits 0-2
// - 16x8: low pins become serial inputs 8-10
// - Non-mux: next pins are address bits 3-5
// - 16x8: next pins become serial inputs 11-13
// - Data strobe high plus select enables access
// - Read low: device drives data bus
// - Read/write level sets bus direction
// - Write low: data bus is input
// - Chip select low required; else ignored
// - Data bus reaches registers and memories
// - Multiplexed: address first on data bus
// - Address latched on strobe falling edge
// - Open-drain acknowledge marks transfer complete
// - Host picks bus style by mode pin
`timescale 1ns/1ps
`include "hport_defines.svh"
module hport_device
  import hport_pkg::*;
#(
  parameter int ADDR_W = `HP_ADDR_W
)
(
  input wire logic clk,
  input wire logic rst_n,
  hport_if.device bus,
  output logic [7:0] mode_reg_out,
  output logic [2:0] extra_serial_in_lo,
  output logic [2:0] extra_serial_in_hi,
  output logic serial_bit_valid,
  output logic [ADDR_W-1:0] last_addr
);

  // ----------------------------------------
  // Strobe synchronisers
  // ----------------------------------------
  localparam int CS = 0;
  localparam int STB = 1;
  localparam int RW = 2;
  localparam int ALE = 3;
  localparam int SCK = 4;

  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic [4:0] prev_reg;
  wire [4:0] raw_pins = {bus.serial_clk, bus.addr_latch_strobe, bus.rw_or_write_n,
                         bus.strobe_or_read_n, bus.cs_n};

  // Two stages, then a third copy for edge detection
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync1_reg <= 5'h07;
      sync2_reg <= 5'h07;
      prev_reg <= 5'h07;
    end
    else
    begin
      sync1_reg <= raw_pins;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  wire style_mux = bus.bus_style_select != BUS_NONMUX;
  wire style_rdwr = bus.bus_style_select == BUS_MUX_RDWR;
  wire selected = !sync2_reg[CS];
  wire rdwr_active = !sync2_reg[STB] || !sync2_reg[RW];
  wire ds_active = sync2_reg[STB];
  wire access_now = selected && (style_rdwr ? rdwr_active : ds_active);
  wire read_now = style_rdwr ? !sync2_reg[STB] : sync2_reg[RW];
  wire ale_fall = style_mux && prev_reg[ALE] && !sync2_reg[ALE];

  dev_state_t state_reg;
  dev_state_t state_next;
  logic [ADDR_W-1:0] latch_reg;
  logic [7:0] mode_reg;
  logic [7:0] rdata_reg;
  logic rd_reg;
  logic [7:0] mem [0:(2**ADDR_W)-1];

  // Non-mux address comes from the shared pins
  wire [ADDR_W-1:0] pin_addr = {{(ADDR_W-6){1'b0}}, bus.high_addr_bits, bus.low_addr_bits};
  wire [ADDR_W-1:0] acc_addr = style_mux ? latch_reg : pin_addr;
  wire start = (state_reg == DEV_IDLE) && access_now;
  wire hit_mode = acc_addr == `DEV_MODE_ADDR;
  wire [7:0] read_value = hit_mode ? mode_reg : mem[acc_addr];

  // ----------------------------------------
  // Address latch
  // ----------------------------------------
  // Host holds the address past the falling edge to cover the sync delay
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      latch_reg <= '0;
    else if (ale_fall)
      latch_reg <= ADDR_W'(bus.host_data_bus);
  end

  // ----------------------------------------
  // Access sequencing
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      DEV_IDLE:
        if (access_now)
          state_next = DEV_ACK;
      DEV_ACK:
        if (!access_now)
          state_next = DEV_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= DEV_IDLE;
      rd_reg <= 1'b0;
      rdata_reg <= 8'h00;
      last_addr <= '0;
    end
    else
    begin
      state_reg <= state_next;
      if (start)
      begin
        rd_reg <= read_now;
        rdata_reg <= read_value;
        last_addr <= acc_addr;
      end
    end
  end

  // Write fires only on the idle-to-ack step, so once per strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      mode_reg <= `DEV_MODE_RST;
    else if (start && !read_now && hit_mode)
      mode_reg <= bus.host_data_bus;
  end

  // Memory has no reset; contents are undefined until written
  always_ff @(posedge clk)
  begin
    if (start && !read_now && !hit_mode)
      mem[acc_addr] <= bus.host_data_bus;
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  assign bus.ack_oe = state_reg == DEV_ACK;
  assign bus.dev_data_oe = (state_reg == DEV_ACK) && rd_reg && access_now;
  assign bus.dev_data_out = rdata_reg;
  assign mode_reg_out = mode_reg;

  // ----------------------------------------
  // Extra serial inputs on address pins
  // ----------------------------------------
  // 2.048 Mb/s is every 2nd edge at 4.096 MHz, every 4th at 8.192 MHz
  logic [1:0] div_reg;
  wire serial_on = mode_reg[`MODE_16X8_BIT] && style_mux;
  wire sck_rise = !prev_reg[SCK] && sync2_reg[SCK];
  wire [1:0] div_last = mode_reg[`MODE_SPEED_BIT] ? 2'h3 : 2'h1;
  wire bit_tick = serial_on && sck_rise && (div_reg == div_last);

  always_ff @(posedge clk)
  begin
    if (!rst_n || !serial_on)
      div_reg <= 2'h0;
    else if (sck_rise)
      div_reg <= bit_tick ? 2'h0 : div_reg + 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      extra_serial_in_lo <= 3'h0;
      extra_serial_in_hi <= 3'h0;
      serial_bit_valid <= 1'b0;
    end
    else
    begin
      serial_bit_valid <= bit_tick;
      if (bit_tick)
      begin
        extra_serial_in_lo <= bus.low_addr_bits;
        extra_serial_in_hi <= bus.high_addr_bits;
      end
    end
  end

endmodule

// *** design/hport_host.sv ***
/*
  CPU end of the switch host port: runs one register or memory access
  on command, in any of the three bus styles, and makes the serial clock.
  Assumes software drives the plain register port below.
*/
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "hport_defines.svh"
module hport_host
  import hport_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  hport_if.host bus,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  logic [7:0] tgt_addr_reg;
  logic [7:0] tgt_wdata_reg;
  logic [7:0] rdata_reg;
  logic [7:0] config_reg;
  logic [5:0] serial_reg;
  logic is_write_reg;
  logic done_reg;
  logic [2:0] cnt_reg;
  host_state_t state_reg;

  wire busy = state_reg != H_IDLE;
  wire cmd_wr = reg_wr && (reg_addr == `REG_CMD);
  // Start while busy is dropped
  wire start = cmd_wr && reg_wdata[`CMD_START_BIT] && !busy;
  bus_style_t style;
  assign style = bus_style_t'(config_reg[1:0]);
  wire style_mux = style != BUS_NONMUX;
  wire style_rdwr = style == BUS_MUX_RDWR;
  wire acked = !bus.transfer_ack_n;
  wire finish = (state_reg == H_RELEASE) && !acked;
  wire done_clr = reg_wr && (reg_addr == `REG_STATUS) && reg_wdata[`STAT_DONE_BIT];

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tgt_addr_reg <= 8'h00;
      tgt_wdata_reg <= 8'h00;
      config_reg <= 8'h00;
      serial_reg <= 6'h00;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `REG_TGT_ADDR)
        tgt_addr_reg <= reg_wdata;
      if (reg_addr == `REG_TGT_WDATA)
        tgt_wdata_reg <= reg_wdata;
      if (reg_addr == `REG_CONFIG)
        config_reg <= {4'h0, reg_wdata[3:0]};
      if (reg_addr == `REG_SERIAL)
        serial_reg <= reg_wdata[5:0];
    end
  end

  // Completion beats a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      done_reg <= 1'b0;
    else if (finish)
      done_reg <= 1'b1;
    else if (done_clr)
      done_reg <= 1'b0;
  end

  wire [7:0] status = {6'h00, done_reg, busy};
  wire [7:0] read_mux = (reg_addr == `REG_TGT_ADDR) ? tgt_addr_reg :
                        (reg_addr == `REG_TGT_WDATA) ? tgt_wdata_reg :
                        (reg_addr == `REG_STATUS) ? status :
                        (reg_addr == `REG_RDATA) ? rdata_reg :
                        (reg_addr == `REG_CONFIG) ? config_reg :
                        (reg_addr == `REG_SERIAL) ? {2'h0, serial_reg} : 8'h00;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= read_mux;
  end

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= H_IDLE;
      cnt_reg <= 3'h0;
      is_write_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end
    else
    begin
      cnt_reg <= cnt_reg + 3'h1;
      unique case (state_reg)
        H_IDLE:
          if (start)
          begin
            is_write_reg <= reg_wdata[`CMD_WRITE_BIT];
            state_reg <= style_mux ? H_ADDR : H_STROBE;
            cnt_reg <= 3'h0;
          end
        H_ADDR:
          if (cnt_reg == 3'(`ADDR_SETUP_CYC - 1))
          begin
            state_reg <= H_LATCH;
            cnt_reg <= 3'h0;
          end
        H_LATCH:
          if (cnt_reg == 3'(`ADDR_HOLD_CYC - 1))
            state_reg <= H_STROBE;
        H_STROBE:
          if (acked)
          begin
            rdata_reg <= is_write_reg ? rdata_reg : bus.host_data_bus;
            state_reg <= H_RELEASE;
          end
        H_RELEASE:
          if (!acked)
            state_reg <= H_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  wire in_strobe = state_reg == H_STROBE;
  wire addr_phase = (state_reg == H_ADDR) || (state_reg == H_LATCH);
  wire drive_serial = config_reg[`CFG_SERIAL_BIT] && style_mux;
  wire [5:0] pin_bits = style_mux ? (drive_serial ? serial_reg : 6'h00) : tgt_addr_reg[5:0];

  assign bus.bus_style_select = style;
  assign bus.cs_n = !in_strobe;
  // Idle levels keep every style inactive
  assign bus.strobe_or_read_n = style_rdwr ? !(in_strobe && !is_write_reg) : in_strobe;
  assign bus.rw_or_write_n = style_rdwr ? !(in_strobe && is_write_reg) : !is_write_reg;
  assign bus.addr_latch_strobe = state_reg == H_ADDR;
  assign bus.low_addr_bits = pin_bits[2:0];
  assign bus.high_addr_bits = pin_bits[5:3];
  assign bus.host_data_oe = addr_phase || (in_strobe && is_write_reg);
  assign bus.host_data_out = addr_phase ? tgt_addr_reg : tgt_wdata_reg;

  // ----------------------------------------
  // Serial clock divider
  // ----------------------------------------
  // Integer halves only approximate the rate from a 40 MHz clock
  logic [2:0] sck_cnt_reg;
  logic sck_reg;
  wire [2:0] half_last = config_reg[`CFG_SPEED_BIT] ? 3'(`SCLK_HALF_FAST - 1) :
                                                      3'(`SCLK_HALF_SLOW - 1);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sck_cnt_reg <= 3'h0;
      sck_reg <= 1'b0;
    end
    else if (sck_cnt_reg >= half_last)
    begin
      sck_cnt_reg <= 3'h0;
      sck_reg <= !sck_reg;
    end
    else
      sck_cnt_reg <= sck_cnt_reg + 3'h1;
  end

  assign bus.serial_clk = sck_reg;

endmodule

// *** dv/hport_props.sv ***
/*
  Checker for the pins between the host and device ends of the port.
  Assumes it is instantiated beside the interface, fed its signals.
*/
`timescale 1ns/1ps
module hport_props
  import hport_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic strobe_or_read_n,
  input wire logic rw_or_write_n,
  input wire logic addr_latch_strobe,
  input wire bus_style_t bus_style_select,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe,
  input wire logic dev_data_oe,
  input wire logic ack_oe,
  input wire logic transfer_ack_n
);
  // ----------------------------------------
  // Pin relations
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Device needs a few cycles to see the end of an access
  a_idle_quiet: assert property (cs_n [*5] |-> !dev_data_oe && !ack_oe)
    else $error("device active while deselected");
  a_ack_start: assert property ($fell(cs_n) |-> ##[1:6] !transfer_ack_n)
    else $error("no acknowledge after select");
  a_ack_end: assert property ($rose(cs_n) |-> ##[1:6] transfer_ack_n)
    else $error("acknowledge held after release");
  a_read_ds: assert property (!cs_n && strobe_or_read_n && rw_or_write_n &&
    bus_style_select != BUS_MUX_RDWR && !transfer_ack_n |-> dev_data_oe)
    else $error("read data not driven");
  a_read_rd: assert property (!cs_n && !strobe_or_read_n &&
    bus_style_select == BUS_MUX_RDWR && !transfer_ack_n |-> dev_data_oe)
    else $error("read line low but bus not driven");
  a_write_input: assert property (!cs_n && !rw_or_write_n |-> !dev_data_oe)
    else $error("device drives bus during write");
  a_one_driver: assert property (!(dev_data_oe && host_data_oe))
    else $error("bus contention");
  a_addr_hold: assert property ($fell(addr_latch_strobe) |->
    (host_data_oe && $stable(host_data_out)) [*4])
    else $error("address not held after latch edge");
  a_ale_unused: assert property (bus_style_select == BUS_NONMUX |-> !addr_latch_strobe)
    else $error("latch strobe used in plain bus mode");
endmodule

// *** dv/cpu_host_port_pin_sharing_test.sv ***
/*
  Bench for the host port pair: drives the controller register port,
  watches the device outputs and the pins between the two ends.
  Assumes the package, interface and both design ends are compiled first.
*/
`timescale 1ns/1ps
`include "hport_defines.svh"
`define CHK(act, exp) begin checks++; if ((act) !== (exp)) begin mismatches++; \
  $display("unexpected at %0t: got %h want %h", $time, act, exp); end end
module cpu_host_port_pin_sharing_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] mode_reg_out;
  logic [2:0] extra_serial_in_lo;
  logic [2:0] extra_serial_in_hi;
  logic serial_bit_valid;
  logic [7:0] last_addr;
  int mismatches = 0;
  int checks = 0;
  int seed = 32'h48ccf47f;
  int s;
  int n;
  int gap;
  logic sp;
  logic [7:0] a;
  logic [7:0] d;
  logic [5:0] v;
  logic [8:0] note;
  logic [8:0] q[$];
  logic rd_d = 1'b0;

  hport_if hif();
  hport_host hport_host_i (.clk(clk), .rst_n(rst_n), .bus(hif.host), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  hport_device #(.ADDR_W(8)) hport_device_i (.clk(clk), .rst_n(rst_n), .bus(hif.device),
    .mode_reg_out(mode_reg_out), .extra_serial_in_lo(extra_serial_in_lo),
    .extra_serial_in_hi(extra_serial_in_hi), .serial_bit_valid(serial_bit_valid),
    .last_addr(last_addr));
  hport_props hport_props_i (.clk(clk), .rst_n(rst_n), .cs_n(hif.cs_n),
    .strobe_or_read_n(hif.strobe_or_read_n), .rw_or_write_n(hif.rw_or_write_n),
    .addr_latch_strobe(hif.addr_latch_strobe), .bus_style_select(hif.bus_style_select),
    .host_data_out(hif.host_data_out), .host_data_oe(hif.host_data_oe),
    .dev_data_oe(hif.dev_data_oe), .ack_oe(hif.ack_oe), .transfer_ack_n(hif.transfer_ack_n));

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // Register port driver
  // ----------------------------------------
  // Strobes stay up between back-to-back cycles; idle lowers them
  task automatic acc(input logic w, input logic [2:0] ad, input logic [7:0] wd,
                     input logic en, input logic [7:0] e);
    reg_addr <= ad;
    reg_wdata <= wd;
    reg_wr <= w;
    reg_rd <= !w;
    if (!w)
      q.push_back({en, e});
    @(posedge clk);
  endtask

  task automatic idle(input int c);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (c) @(posedge clk);
  endtask

  task automatic wait_done;
    int k;
    k = 0;
    do
    begin
      acc(1'b0, `REG_STATUS, 8'h00, 1'b0, 8'h00);
      idle(1);
      k++;
    end
    while (reg_rdata[`STAT_DONE_BIT] !== 1'b1 && k < 200);
    `CHK(reg_rdata[`STAT_DONE_BIT], 1'b1)
    acc(1'b1, `REG_STATUS, 8'h02, 1'b0, 8'h00);
  endtask

  task automatic dev(input logic w, input logic [7:0] ad, input logic [7:0] wd);
    acc(1'b1, `REG_TGT_ADDR, ad, 1'b0, 8'h00);
    acc(1'b1, `REG_TGT_WDATA, wd, 1'b0, 8'h00);
    acc(1'b1, `REG_CMD, {6'h00, w, 1'b1}, 1'b0, 8'h00);
    idle(1);
    wait_done;
  endtask

  // Read data stand from the cycle after the strobe until the next read
  always @(posedge clk)
  begin
    if (rd_d)
    begin
      note = q.pop_front();
      if (note[8])
        `CHK(reg_rdata, note[7:0])
    end
    rd_d <= reg_rd;
  end

  task automatic end_sim;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim;
  end

  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK(mode_reg_out, `DEV_MODE_RST)
    `CHK(hif.cs_n, 1'b1)
    acc(1'b0, `REG_STATUS, 8'h00, 1'b1, 8'h00);
    acc(1'b0, 3'h7, 8'h00, 1'b1, 8'h00);
    idle(1);
    for (s = 0; s < 3; s++)
    begin
      sp = s[0];
      a = 8'($random(seed));
      d = 8'($random(seed));
      if (s == 0)
        a[7:6] = 2'b00;
      if (a == 8'h00)
        a = 8'h01;
      acc(1'b1, `REG_CONFIG, {5'h00, sp, s[1:0]}, 1'b0, 8'h00);
      dev(1'b1, a, d);
      `CHK(last_addr, a)
      dev(1'b0, a, 8'h00);
      acc(1'b0, `REG_RDATA, 8'h00, 1'b1, d);
      idle(1);
      dev(1'b1, 8'h00, {6'h00, sp, 1'b0});
      `CHK(mode_reg_out, {6'h00, sp, 1'b0})
    end
    // Extra serial inputs on the address pins, fast then slow clock
    for (s = 0; s < 2; s++)
    begin
      sp = !s[0];
      v = 6'($random(seed));
      // Every serial bit lasts one 2.048 Mb/s slot at either clock rate
      gap = sp ? 2 * `SCLK_HALF_FAST * (`SCLK_FAST_KHZ / 2048) :
                 2 * `SCLK_HALF_SLOW * (`SCLK_SLOW_KHZ / 2048);
      acc(1'b1, `REG_CONFIG, {5'h00, sp, 2'h1}, 1'b0, 8'h00);
      dev(1'b1, 8'h00, {6'h00, sp, 1'b1});
      `CHK(mode_reg_out, {6'h00, sp, 1'b1})
      acc(1'b1, `REG_CONFIG, {5'h01, sp, 2'h1}, 1'b0, 8'h00);
      acc(1'b1, `REG_SERIAL, {2'b00, v}, 1'b0, 8'h00);
      idle(1);
      // Gap between the second and third bits is measured, after the divider has settled
      repeat (3)
      begin
        @(posedge clk);
        n = 0;
        while (serial_bit_valid !== 1'b1 && n < 100)
        begin
          @(posedge clk);
          n++;
        end
      end
      `CHK(serial_bit_valid, 1'b1)
      `CHK(n + 1, gap)
      `CHK(extra_serial_in_lo, v[2:0])
      `CHK(extra_serial_in_hi, v[5:3])
    end
    idle(4);
    end_sim;
  end
endmodule
